/* File: shared/agc_mon_cfg.svh */
`ifndef AGC_MON_CFG_SVH
`define AGC_MON_CFG_SVH
// How it works
// - very-low flag rises once peaks above very-low threshold outnumber very-low count.
// - low flag rises once peaks above low threshold outnumber low count.
// - high flag rises once peaks above high threshold outnumber high count.
// - fast attack off: very-low or low flag set at period end blocks that period's gain decrement.
// - fast attack on: rising high flag requests a decrement at once.
// - fast attack off: high flag requests its decrement only at counter expiry.
// - counter expiry clears the very-low, low and high flags and their peak counts, and sets the expired flag.
// - each channel reports gain update counter expiry.
// - row 0x42 carries rx2 flags on D7..D4, rx1 flags on D3..D0.
// - row 0x43 carries zeros on D7..D4, observation flags on D3..D0.
// - programmed row select picks which eight signals reach the monitor.
// - mask bit n enables monitor bit Dn.
// - monitor bits with a clear mask bit are driven low.
// - each pin nibble independently takes the monitor function or not.
// - with both nibbles in monitor mode and enabled, Dn appears on pin n.
// - row select and mask read back; mask 1 means enabled.
// - row 0x42 is the two-receiver overrange row.

`define PEAK_W 8
`define CNT_W 8
`define PER_W 16

`define OFS_CTRL 12'h000
`define OFS_MON 12'h004
`define OFS_PIN 12'h008
`define OFS_PERIOD 12'h00C
`define OFS_THRESH 12'h010
`define OFS_COUNT 12'h014
`define OFS_STATUS 12'h018

`define CTRL_AGC_EN 0
`define CTRL_FAST 1
`define MON_MASK_LSB 8
`define PIN_OE_LSB 8

`define RST_PERIOD 16'h00FF
`define RST_THRESH 24'hC08040
`define RST_COUNT 24'h040404

`define ROW_RX 8'h42
`define ROW_ORX 8'h43
`endif

/* File: shared/agc_mon_pkg.sv */
`include "agc_mon_cfg.svh"
package agc_mon_pkg;
  // field order gives bit order 3..0 on a monitor row
  typedef struct packed
  {
    logic veryLow;
    logic low;
    logic high;
    logic expired;
  } ovrFlags_s;

  typedef struct packed
  {
    logic [`PEAK_W-1:0] vlThr;
    logic [`PEAK_W-1:0] lowThr;
    logic [`PEAK_W-1:0] highThr;
    logic [`CNT_W-1:0]  vlCnt;
    logic [`CNT_W-1:0]  lowCnt;
    logic [`CNT_W-1:0]  highCnt;
    logic [`PER_W-1:0]  period;
    logic               fastAttack;
    logic               agcEnable;
  } chanCfg_s;

  typedef struct packed
  {
    logic [`CNT_W-1:0] vlCount;
    logic [`CNT_W-1:0] lowCount;
    logic [`CNT_W-1:0] highCount;
    logic [`PER_W-1:0] timer;
    ovrFlags_s         flags;
    logic              decrement;
  } chanState_s;

  typedef enum logic [1:0]
  {
    BUS_IDLE = 2'b01,
    BUS_WAIT = 2'b10
  } busState_e;

  typedef struct packed
  {
    busState_e   bus;
    logic [1:0]  ctrl;
    logic [7:0]  monRow;
    logic [7:0]  monMask;
    logic [1:0]  srcSel;
    logic [7:0]  pinOe;
    logic [15:0] period;
    logic [23:0] thresh;
    logic [23:0] count;
    logic [31:0] rdata;
    logic        ready;
    logic        slvErr;
    logic [7:0]  pinOut;
    logic [7:0]  pinEn;
    logic [2:0]  decOut;
  } topState_s;
endpackage

/* File: hdl/overrange_channel.sv */
`include "agc_mon_cfg.svh"
module overrange_channel
  import agc_mon_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst_b,
  input  wire chanCfg_s           cfg,
  input  wire logic [`PEAK_W-1:0] peakMag,
  input  wire logic               peakValid,
  output ovrFlags_s               flags,
  output logic                    gainDecrement
);
  chanState_s q;
  chanState_s d;
  logic       expire;
  logic [`CNT_W-1:0] nVl;
  logic [`CNT_W-1:0] nLow;
  logic [`CNT_W-1:0] nHigh;

  // saturating so a long burst cannot wrap and drop the flag
  function automatic logic [`CNT_W-1:0] bump(input logic [`CNT_W-1:0] c, input logic hit);
    bump = (hit && (c != {`CNT_W{1'b1}})) ? c + 1'b1 : c;
  endfunction

  always_comb
  begin
    d = q;
    expire = cfg.agcEnable && (q.timer >= cfg.period);
    d.timer = (expire || !cfg.agcEnable) ? '0 : q.timer + 1'b1;
    // a peak in the expiry cycle opens the new period, so it is kept
    nVl = bump(expire ? '0 : q.vlCount, peakValid && (peakMag > cfg.vlThr));
    nLow = bump(expire ? '0 : q.lowCount, peakValid && (peakMag > cfg.lowThr));
    nHigh = bump(expire ? '0 : q.highCount, peakValid && (peakMag > cfg.highThr));
    d.vlCount = nVl;
    d.lowCount = nLow;
    d.highCount = nHigh;
    d.flags.veryLow = (q.flags.veryLow && !expire) || (nVl > cfg.vlCnt);
    d.flags.low = (q.flags.low && !expire) || (nLow > cfg.lowCnt);
    d.flags.high = (q.flags.high && !expire) || (nHigh > cfg.highCnt);
    d.flags.expired = expire;
    d.decrement = 1'b0;
    if (cfg.fastAttack && d.flags.high && (expire || !q.flags.high))
    begin
      d.decrement = 1'b1;
    end
    if (expire && !cfg.fastAttack && q.flags.high && !(q.flags.veryLow || q.flags.low))
    begin
      d.decrement = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign flags = q.flags;
  assign gainDecrement = q.decrement;
endmodule

/* File: hdl/monitor_row_mux.sv */
`include "agc_mon_cfg.svh"
module monitor_row_mux
  import agc_mon_pkg::*;
(
  input  wire logic [7:0] monitor_row_select,
  input  wire logic [7:0] monitor_bit_mask,
  input  wire ovrFlags_s  rx1Flags,
  input  wire ovrFlags_s  rx2Flags,
  input  wire ovrFlags_s  orxFlags,
  output logic [7:0]      monWord
);
  // rows outside this block read as zero
  function automatic logic [7:0] rowBits(input logic [7:0] row,
                                         input ovrFlags_s r1,
                                         input ovrFlags_s r2,
                                         input ovrFlags_s ob);
    case (row)
      `ROW_RX:  rowBits = {r2, r1};
      `ROW_ORX: rowBits = {4'h0, ob};
      default:  rowBits = 8'h00;
    endcase
  endfunction

  always_comb
  begin
    monWord = rowBits(monitor_row_select, rx1Flags, rx2Flags, orxFlags)
              & monitor_bit_mask;
  end
endmodule

/* File: hdl/agc_overrange_monitor_mux.sv */
// The APB slave port and the address map were chosen for this implementation.
`include "agc_mon_cfg.svh"
module agc_overrange_monitor_mux
  import agc_mon_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [2:0][`PEAK_W-1:0] peakMag,
  input  wire logic [2:0]              peakValid,
  output logic [2:0]                   gainDecrement,
  output logic [7:0]                   monPinOut,
  output logic [7:0]                   monPinOe
);
  topState_s   q;
  topState_s   d;
  chanCfg_s    cfg;
  ovrFlags_s   chFlags [3];
  logic [2:0]  chDec;
  logic [7:0]  monWord;
  logic        access;
  logic        hit;
  logic [31:0] rd;

  always_comb
  begin
    cfg.vlThr = q.thresh[7:0];
    cfg.lowThr = q.thresh[15:8];
    cfg.highThr = q.thresh[23:16];
    cfg.vlCnt = q.count[7:0];
    cfg.lowCnt = q.count[15:8];
    cfg.highCnt = q.count[23:16];
    cfg.period = q.period;
    cfg.fastAttack = q.ctrl[`CTRL_FAST];
    cfg.agcEnable = q.ctrl[`CTRL_AGC_EN];
  end

  // channel 0 rx1, 1 rx2, 2 observation receiver
  for (genvar c = 0; c < 3; c++)
  begin : gChan
    overrange_channel uChan
    (
      .clk_sys       (clk_sys),
      .rst_b         (rst_b),
      .cfg           (cfg),
      .peakMag       (peakMag[c]),
      .peakValid     (peakValid[c]),
      .flags         (chFlags[c]),
      .gainDecrement (chDec[c])
    );
  end

  monitor_row_mux uMux
  (
    .monitor_row_select (q.monRow),
    .monitor_bit_mask   (q.monMask),
    .rx1Flags           (chFlags[0]),
    .rx2Flags           (chFlags[1]),
    .orxFlags           (chFlags[2]),
    .monWord            (monWord)
  );

  always_comb
  begin
    hit = 1'b1;
    rd = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL:   rd = {30'h0, q.ctrl};
      `OFS_MON:    rd = {16'h0, q.monMask, q.monRow};
      `OFS_PIN:    rd = {16'h0, q.pinOe, 6'h00, q.srcSel};
      `OFS_PERIOD: rd = {16'h0, q.period};
      `OFS_THRESH: rd = {8'h00, q.thresh};
      `OFS_COUNT:  rd = {8'h00, q.count};
      `OFS_STATUS: rd = {17'h0, chDec, chFlags[2], chFlags[1], chFlags[0]};
      default:     hit = 1'b0;
    endcase
  end

  always_comb
  begin
    d = q;
    access = psel && penable;
    d.ready = 1'b0;
    d.slvErr = 1'b0;
    // one wait state: read data is captured on the edge that raises pready, a write lands on the edge that samples it
    case (q.bus)
      BUS_IDLE:
      begin
        if (access)
        begin
          d.bus = BUS_WAIT;
          d.ready = 1'b1;
          d.slvErr = !hit;
          d.rdata = (pwrite || !hit) ? 32'h0000_0000 : rd;
        end
      end
      BUS_WAIT:
      begin
        d.bus = BUS_IDLE;
        if (access && pwrite && hit)
        begin
          case (paddr)
            `OFS_CTRL:   d.ctrl = pwdata[1:0];
            `OFS_MON:
            begin
              d.monRow = pwdata[7:0];
              d.monMask = pwdata[`MON_MASK_LSB +: 8];
            end
            `OFS_PIN:
            begin
              d.srcSel = pwdata[1:0];
              d.pinOe = pwdata[`PIN_OE_LSB +: 8];
            end
            `OFS_PERIOD: d.period = pwdata[15:0];
            `OFS_THRESH: d.thresh = pwdata[23:0];
            `OFS_COUNT:  d.count = pwdata[23:0];
            default:     d.ctrl = q.ctrl;
          endcase
        end
      end
      default: d.bus = BUS_IDLE;
    endcase
    // non-monitor nibbles drive low where enabled; disabled pins hold pinOut low with their enable off
    for (int i = 0; i < 8; i++)
    begin
      d.pinOut[i] = monWord[i] && q.srcSel[i / 4] && q.pinOe[i];
    end
    d.pinEn = q.pinOe;
    d.decOut = chDec;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '0;
      q.bus <= BUS_IDLE;
      q.period <= `RST_PERIOD;
      q.thresh <= `RST_THRESH;
      q.count <= `RST_COUNT;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata = q.rdata;
  assign pready = q.ready;
  assign pslverr = q.slvErr;
  assign monPinOut = q.pinOut;
  assign monPinOe = q.pinEn;
  assign gainDecrement = q.decOut;
endmodule

/* File: tb/agc_mon_checker.sv */
module agc_mon_checker
  import agc_mon_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  gainDecrement,
  input wire logic [7:0]  monPinOut,
  input wire logic [7:0]  monPinOe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_pin_gated: assert property ((monPinOut & ~monPinOe) == 8'h00)
    else $error("monitor pin high with its enable low");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_one_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("pready missing in second access cycle");
  a_no_early: assert property (psel && !penable |=> !pready)
    else $error("pready during setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  // enables move only after a register write has landed
  a_oe_steady: assert property ($stable(monPinOe) || $past(pready && pwrite)
    || $past(pready && pwrite, 2)) else $error("pin enables moved with no write");
  cover property (pready && !pwrite);
  cover property (|gainDecrement);
  cover property (monPinOut[0]);
endmodule

bind agc_overrange_monitor_mux agc_mon_checker chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .gainDecrement(gainDecrement), .monPinOut(monPinOut),
  .monPinOe(monPinOe));

/* File: tb/pin_watcher.sv */
module pin_watcher
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] monPinOut,
  input  wire logic [7:0] monPinOe,
  output logic      [7:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;
  // undriven pins read low: board pull-downs assumed on the monitor pins
  always @(posedge clk_sys)
    seen <= monPinOut & monPinOe;
endmodule

/* File: tb/agc_overrange_monitor_mux_bench.sv */
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module agc_overrange_monitor_mux_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk_sys = 0;
  logic            rst_b = 0;
  logic            psel = 0, penable = 0, pwrite = 0;
  logic [11:0]     paddr = 0;
  logic [31:0]     pwdata = 0, prdata;
  logic [32:0]     expv, gotv;
  logic            pready, pslverr;
  logic [2:0][7:0] peakMag = 0;
  logic [2:0]      peakValid = 0, gainDecrement;
  logic [7:0]      monPinOut, monPinOe, seen, hi, vl;
  logic [32:0]     expQ[$];
  logic [31:0]     rstTab[8] = '{32'h0, 32'h0, 32'h0, 32'h0000_00FF, 32'h00C0_8040,
                                 32'h0004_0404, 32'h0, 32'h0};
  int              mismatches = 0, compares = 0, n;

  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  agc_overrange_monitor_mux uut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .peakMag(peakMag), .peakValid(peakValid),
    .gainDecrement(gainDecrement), .monPinOut(monPinOut), .monPinOe(monPinOe));
  pin_watcher peer (.clk_sys(clk_sys), .monPinOut(monPinOut), .monPinOe(monPinOe),
    .seen(seen));

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic bound(input int lim);
    if (n >= lim)
    begin
      mismatches++;
      finish_test();
    end
  endtask

  // for reads d is the expected word, checked by the watcher process below
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    if (!w)
      expQ.push_back({a > 12'h018, d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // request stands until the rising edge that samples pready high
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1)
        break;
    end
    bound(20);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic peak(input int ch, input logic [7:0] m);
    @(posedge clk_sys);
    peakMag[ch] <= m;
    peakValid[ch] <= 1'b1;
    @(posedge clk_sys);
    peakValid[ch] <= 1'b0;
  endtask

  task automatic pins(input logic [7:0] e);
    repeat (4) @(negedge clk_sys);
    `CHK(seen, e)
  endtask

  // read data and error flag are taken at the edge that samples pready high
  always @(posedge clk_sys)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      expv = expQ.pop_front();
      gotv = {pslverr, prdata};
      `CHK(gotv, expv)
    end

  initial
  begin
    void'($urandom(59034));
    hi = 8'($urandom_range(255, 193));
    vl = 8'($urandom_range(128, 65));
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    foreach (rstTab[i]) apb(1'b0, 12'(i * 4), rstTab[i]);
    apb(1'b1, 12'h004, {16'h0, hi, 8'h42});
    apb(1'b0, 12'h004, {16'h0, hi, 8'h42});
    $display("test registers done");
    // slow period keeps expiry well clear of the flag checks
    apb(1'b1, 12'h00C, 32'h0000_0200);
    apb(1'b1, 12'h014, 32'h0001_0101);
    apb(1'b1, 12'h008, 32'h0000_FF03);
    apb(1'b1, 12'h004, 32'h0000_FF42);
    apb(1'b1, 12'h000, 32'h0000_0001);
    peak(0, hi);
    pins(8'h00);
    peak(0, hi);
    pins(8'h0E);
    peak(1, vl);
    peak(1, vl);
    pins(8'h8E);
    `CHK(gainDecrement, 3'b000)
    apb(1'b0, 12'h018, 32'h0000_008E);
    apb(1'b1, 12'h004, 32'h0000_0F42);
    pins(8'h0E);
    apb(1'b1, 12'h008, 32'h0000_FF02);
    apb(1'b1, 12'h004, 32'h0000_FF42);
    pins(8'h80);
    apb(1'b1, 12'h008, 32'h0000_3C03);
    pins(8'h0C);
    `CHK(monPinOe, 8'h3C)
    apb(1'b1, 12'h004, 32'h0000_FF41);
    pins(8'h00);
    apb(1'b1, 12'h004, 32'h0000_FF42);
    apb(1'b1, 12'h008, 32'h0000_FF03);
    $display("test flags done");
    for (n = 0; n < 700 && monPinOut[0] !== 1'b1; n++)
      @(negedge clk_sys);
    bound(700);
    repeat (4)
    begin
      `CHK(gainDecrement, 3'b000)
      @(negedge clk_sys);
      `CHK(monPinOut[0], 1'b0)
    end
    pins(8'h00);
    apb(1'b1, 12'h010, 32'h0080_FFFF);
    peak(2, hi);
    peak(2, hi);
    apb(1'b1, 12'h004, 32'h0000_FF43);
    pins(8'h02);
    for (n = 0; n < 700 && gainDecrement === 3'b000; n++)
      @(negedge clk_sys);
    bound(700);
    `CHK(gainDecrement, 3'b100)
    `CHK(n > 50, 1'b1)
    pins(8'h00);
    $display("test slow decrement done");
    apb(1'b1, 12'h000, 32'h0000_0003);
    peak(1, hi);
    peak(1, hi);
    for (n = 0; n < 4 && gainDecrement === 3'b000; n++)
      @(negedge clk_sys);
    `CHK(gainDecrement, 3'b010)
    $display("test fast decrement done");
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    $display("test second reset done");
    finish_test();
  end
endmodule
